// >>> rtl/sees_pkg.sv
/*
 * Constants for the slot event enable and status block.
 * Assumes a 16-bit configuration access port on the core clock.
 */
package sees_pkg;
	// register offsets
	localparam logic [7:0]  STATUS_OFFSET   = 8'hAA;
	localparam logic [7:0]  CONTROL_OFFSET  = 8'hA8;
	// reset values
	localparam logic [15:0] STATUS_RESET    = 16'h0010;
	localparam logic [15:0] CONTROL_RESET   = 16'h0000;
	// field positions of status; bits 0 to 2 also used by control
	localparam int          BUTTON_BIT      = 0;
	localparam int          FAULT_BIT       = 1;
	localparam int          LATCH_BIT       = 2;
	localparam int          PRESENCE_BIT    = 3;
	localparam int          DONE_BIT        = 4;
	localparam int          LATCH_STATE_BIT = 5;
	localparam int          PRESENT_BIT     = 6;
	localparam int          INTERLOCK_BIT   = 7;
	localparam int          LINK_CHANGE_BIT = 8;
	// change flags cleared by writing one
	localparam logic [15:0] CLEAR_MASK      = 16'h011F;
	// writable slot control bits
	localparam logic [15:0] CONTROL_MASK    = 16'h1FFF;
	// command busy time, in ns, and as cycles at 200 MHz
	localparam int          CLOCK_NS        = 5;
	localparam int          COMMAND_NS      = 100;
	localparam int          COMMAND_CYCLES  = (COMMAND_NS + CLOCK_NS - 1) / CLOCK_NS;
	// power states
	localparam logic [1:0]  POWER_D0        = 2'h0;
endpackage

// >>> rtl/sees_flag.sv
/*
 * One sticky change flag: hardware set, write-one clear.
 * Assumes set and clear arrive on the core clock.
 */
`timescale 1ns/1ps
module sees_flag (
	input  wire logic clock_i,
	input  wire logic reset_i,
	input  wire logic enable_i,
	input  wire logic set_i,
	input  wire logic clear_i,
	input  wire logic reset_value_i,
	output logic      flag_o
);
	typedef struct packed {
		logic flag;
	} sees_flag_state_type;

	sees_flag_state_type state_q;
	sees_flag_state_type state_d;

	// set wins over a clear in the same cycle
	always_comb begin
		state_d = state_q;
		if (clear_i) begin
			state_d.flag = 1'b0;
		end
		if (set_i) begin
			state_d.flag = 1'b1;
		end
	end

	// register; reset loads this flag's own reset value
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			state_q      <= '0;
			state_q.flag <= reset_value_i;
		end else if (enable_i) begin
			state_q <= state_d;
		end
	end

	assign flag_o = state_q.flag;
endmodule // sees_flag

// >>> rtl/sees_top.sv
/*
 * Slot control enables and slot status flags of a hot-plug slot,
 * forming hot-plug interrupt and power event requests.
 * Assumes a configuration access port on the core clock and hardware
 * event pulses from the same clock domain.
 */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Slot control bit 2 is read-write and enables requests from the latch sensor change flag.
// - Slot control bit 1 is read-write and enables requests from the power fault flag.
// - Slot control bit 0 is read-write and enables requests from the button pressed flag.
// - A hot-plug interrupt also needs the hot-plug and message interrupt enables set.
// - In D1, D2 or D3hot a power event is signalled only with the power event enable set.
// - Slot status is a 16-bit register at offset AAh holding slot state and change flags.
// - Slot status reads 0010h after reset.
// - Slot status is hardware updated and software writes only clear change flags.
// - Status bit 4 is set when the controller can accept another command.
// - Writing one to a change flag clears it and writing zero leaves it.
module sees_top (
	input  wire logic        clock_i,
	input  wire logic        reset_i,
	input  wire logic        enable_i,
	input  wire logic        cfg_write_i,
	input  wire logic        cfg_read_i,
	input  wire logic [7:0]  cfg_offset_i,
	input  wire logic [15:0] cfg_wdata_i,
	output logic      [15:0] cfg_rdata_o,
	output logic             cfg_rvalid_o,
	input  wire logic        hotplug_irq_enable_i,
	input  wire logic        message_irq_enable_i,
	input  wire logic        power_event_enable_i,
	input  wire logic [1:0]  power_state_i,
	input  wire logic        latch_sensor_changed_set_i,
	input  wire logic        power_fault_detected_set_i,
	input  wire logic        button_pressed_set_i,
	input  wire logic        presence_changed_set_i,
	input  wire logic        link_changed_set_i,
	input  wire logic        latch_state_i,
	input  wire logic        present_i,
	input  wire logic        interlock_i,
	output logic             hotplug_irq_o,
	output logic             power_event_o,
	output logic [15:0]      slot_event_control_o
);
	typedef struct packed {
		logic [15:0] control;  // slot control, bits 15:13 held zero
		logic [15:0] rdata;    // registered read answer
		logic        rvalid;   // read answer strobe
		logic        irq;      // hot-plug interrupt request
		logic        pme;      // power event request
		logic [7:0]  busy;     // command busy countdown
		logic [2:0]  sync1;    // first stage of the pin synchroniser
		logic [2:0]  live;     // second stage, the only one logic reads
	} sees_state_type;

	// all state of the block except the change flags, registered as one
	sees_state_type state_q;
	sees_state_type state_d;

	////////////////////////////////////////////////////////////////////////////
	// decode
	logic        hit_status;
	logic        hit_control;
	logic        wr_status;
	logic        wr_control;
	logic        command_done;
	logic [2:0]  pins;
	logic [15:0] clear_bits;
	logic [15:0] set_bits;
	logic [15:0] flags;
	logic [15:0] status;

	// offset match for the write strobes
	assign hit_status   = (cfg_offset_i == sees_pkg::STATUS_OFFSET);
	assign hit_control  = (cfg_offset_i == sees_pkg::CONTROL_OFFSET);
	assign wr_status    = cfg_write_i && hit_status;
	assign wr_control   = cfg_write_i && hit_control;

	// software may only clear change flags; other status bits ignore writes
	assign clear_bits   = wr_status ? (cfg_wdata_i & sees_pkg::CLEAR_MASK) : 16'h0000;

	// countdown about to expire: the controller takes a new command
	assign command_done = (state_q.busy == 8'h01);

	// pin levels in status bit order
	assign pins         = {interlock_i, present_i, latch_state_i};

	// hardware set sources; a set beats a clear in the same cycle
	always_comb begin
		set_bits = 16'h0000;
		set_bits[sees_pkg::BUTTON_BIT]      = button_pressed_set_i;
		set_bits[sees_pkg::FAULT_BIT]       = power_fault_detected_set_i;
		set_bits[sees_pkg::LATCH_BIT]       = latch_sensor_changed_set_i;
		set_bits[sees_pkg::PRESENCE_BIT]    = presence_changed_set_i;
		set_bits[sees_pkg::DONE_BIT]        = command_done;
		set_bits[sees_pkg::LINK_CHANGE_BIT] = link_changed_set_i;
	end

	////////////////////////////////////////////////////////////////////////////
	// change flags, one instance per clearable bit
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_flag
			if (sees_pkg::CLEAR_MASK[gi]) begin : g_on
				sees_flag u_flag (
					.clock_i       (clock_i),
					.reset_i       (reset_i),
					.enable_i      (enable_i),
					.set_i         (set_bits[gi]),
					.clear_i       (clear_bits[gi]),
					.reset_value_i (sees_pkg::STATUS_RESET[gi]),
					.flag_o        (flags[gi])
				);
			end else begin : g_off
				assign flags[gi] = 1'b0;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// status view and named fields
	logic latch_sensor_change_enable;
	logic power_fault_enable;
	logic button_press_enable;
	logic latch_sensor_changed;
	logic power_fault_detected;
	logic button_pressed;

	// status view: flags plus live pin levels; reserved bits read zero
	always_comb begin
		status = flags;
		status[sees_pkg::LATCH_STATE_BIT] = state_q.live[0];
		status[sees_pkg::PRESENT_BIT]     = state_q.live[1];
		status[sees_pkg::INTERLOCK_BIT]   = state_q.live[2];
	end

	// event enables held in slot control
	assign latch_sensor_change_enable = state_q.control[sees_pkg::LATCH_BIT];
	assign power_fault_enable         = state_q.control[sees_pkg::FAULT_BIT];
	assign button_press_enable        = state_q.control[sees_pkg::BUTTON_BIT];

	// change flags that those enables arm
	assign latch_sensor_changed       = flags[sees_pkg::LATCH_BIT];
	assign power_fault_detected       = flags[sees_pkg::FAULT_BIT];
	assign button_pressed             = flags[sees_pkg::BUTTON_BIT];

	////////////////////////////////////////////////////////////////////////////
	// event requests
	logic [2:0] armed;
	logic       any_event;
	logic       irq_gate;
	logic       pme_gate;

	// flag and enable, so enabling an already set flag still requests
	assign armed[2]  = latch_sensor_changed & latch_sensor_change_enable;
	assign armed[1]  = power_fault_detected & power_fault_enable;
	assign armed[0]  = button_pressed & button_press_enable;
	assign any_event = |armed;

	// an interrupt also needs both interrupt enables
	assign irq_gate  = hotplug_irq_enable_i & message_irq_enable_i;

	// outside D0 a power event also needs its enable
	assign pme_gate  = (power_state_i == sees_pkg::POWER_D0) | power_event_enable_i;

	////////////////////////////////////////////////////////////////////////////
	// command tracking
	logic command_busy;

	// countdown still running after the last control write
	assign command_busy = (state_q.busy != 8'h00);

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		state_d = state_q;
		// two-flop synchroniser for the asynchronous pin levels
		state_d.sync1 = pins;
		state_d.live  = state_q.sync1;
		// a control write is a command and restarts the busy countdown
		if (wr_control) begin
			state_d.control = cfg_wdata_i & sees_pkg::CONTROL_MASK;
			state_d.busy    = 8'(sees_pkg::COMMAND_CYCLES);
		end else if (command_busy) begin
			state_d.busy = state_q.busy - 8'h01;
		end
		// read answer one cycle after the strobe; unmapped offsets read zero
		state_d.rvalid = cfg_read_i;
		unique case (cfg_offset_i)
			sees_pkg::STATUS_OFFSET: begin
				state_d.rdata = status;
			end
			sees_pkg::CONTROL_OFFSET: begin
				state_d.rdata = state_q.control;
			end
			default: begin
				state_d.rdata = 16'h0000;
			end
		endcase
		// requests registered so the outputs come straight from flops
		state_d.irq = any_event & irq_gate;
		state_d.pme = any_event & pme_gate;
	end

	// register; enable low freezes everything, reset wins over it
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			state_q         <= '0;
			state_q.control <= sees_pkg::CONTROL_RESET;
		end else if (enable_i) begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign cfg_rdata_o          = state_q.rdata;
	assign cfg_rvalid_o         = state_q.rvalid;
	assign hotplug_irq_o        = state_q.irq;
	assign power_event_o        = state_q.pme;
	assign slot_event_control_o = state_q.control;
endmodule // sees_top

// >>> tb/sees_top_sva.sv
/* port checker for sees_top
   assumes sees_pkg is compiled first */
`timescale 1ns/1ps
module sees_top_sva (
	input wire logic        clock_i,
	input wire logic        reset_i,
	input wire logic        enable_i,
	input wire logic        cfg_write_i,
	input wire logic        cfg_read_i,
	input wire logic [7:0]  cfg_offset_i,
	input wire logic [15:0] cfg_wdata_i,
	input wire logic [15:0] cfg_rdata_o,
	input wire logic        cfg_rvalid_o,
	input wire logic        hotplug_irq_enable_i,
	input wire logic        message_irq_enable_i,
	input wire logic        power_event_enable_i,
	input wire logic [1:0]  power_state_i,
	input wire logic        hotplug_irq_o,
	input wire logic        power_event_o,
	input wire logic [15:0] slot_event_control_o
);
	// one clock domain
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	sequence s_ctl_wr; enable_i && cfg_write_i && cfg_offset_i == sees_pkg::CONTROL_OFFSET; endsequence
	sequence s_sts_wr; cfg_write_i && cfg_offset_i == sees_pkg::STATUS_OFFSET; endsequence
	sequence s_sts_rd; cfg_read_i && cfg_offset_i == sees_pkg::STATUS_OFFSET; endsequence
	sequence s_pme_gated; power_event_o && $past(power_state_i) != sees_pkg::POWER_D0; endsequence
	a_ctl_write: assert property (s_ctl_wr |=> slot_event_control_o[2:0] == $past(cfg_wdata_i[2:0]))
		else $error("enable bits not written");
	a_sts_write: assert property (s_sts_wr |=> $stable(slot_event_control_o))
		else $error("status write changed control");
	a_irq_gates: assert property (hotplug_irq_o |-> $past(hotplug_irq_enable_i && message_irq_enable_i))
		else $error("irq without gates");
	a_irq_enable: assert property (hotplug_irq_o |-> $past(|slot_event_control_o[2:0]))
		else $error("irq without enable");
	a_pme_gate: assert property (s_pme_gated |-> $past(power_event_enable_i))
		else $error("power event while gated");
	a_read_answer: assert property (cfg_rvalid_o == ($past(enable_i) ? $past(cfg_read_i) : $past(cfg_rvalid_o)))
		else $error("read answer timing");
	a_sts_reserved: assert property (s_sts_rd |=> cfg_rdata_o[15:9] == 7'h00)
		else $error("reserved status bits set");
	a_ctl_frozen: assert property (!enable_i |=> $stable(slot_event_control_o))
		else $error("control changed while frozen");
	a_reset_clear: assert property ($fell(reset_i) |-> !hotplug_irq_o && slot_event_control_o == 16'h0000)
		else $error("outputs not cleared by reset");
endmodule // sees_top_sva
////////////////////////////////////////////////////////////////////////////////
bind sees_top sees_top_sva sees_top_sva_i (.*);

// >>> tb/testbench.sv
/* random and corner tests of sees_top
   assumes sees_pkg and the checker are compiled first */
`timescale 1ns/1ps
module testbench;
	logic        clock_i = 0, reset_i = 1, en = 1, wr = 0, rd = 0, hpi = 0, msi = 0, pe = 0, rv, irq, pme;
	logic [1:0]  ps = 0;
	logic [2:0]  fset = 0, lvl = 0;
	logic [7:0]  off = 0;
	logic [15:0] wd = 0, rdata, ctl;
	int          mismatches = 0, num_checks = 0, seed = 32'h0d55;
	sees_top sees_top_i (.clock_i(clock_i), .reset_i(reset_i), .enable_i(en), .cfg_write_i(wr),
		.cfg_read_i(rd), .cfg_offset_i(off), .cfg_wdata_i(wd), .cfg_rdata_o(rdata), .cfg_rvalid_o(rv),
		.hotplug_irq_enable_i(hpi), .message_irq_enable_i(msi), .power_event_enable_i(pe),
		.power_state_i(ps), .latch_sensor_changed_set_i(fset[2]), .power_fault_detected_set_i(fset[1]),
		.button_pressed_set_i(fset[0]), .presence_changed_set_i(1'b0), .link_changed_set_i(1'b0),
		.latch_state_i(lvl[0]), .present_i(lvl[1]), .interlock_i(lvl[2]), .hotplug_irq_o(irq),
		.power_event_o(pme), .slot_event_control_o(ctl));
	// 200 MHz core clock
	always #2.5 clock_i = ~clock_i;
	////////////////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp({15'h0000, got}, {15'h0000, exp});
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic write(input logic [7:0] o, input logic [15:0] d);
		off = o;
		wd = d;
		wr = 1;
		@(negedge clock_i);
		wr = 0;
		@(negedge clock_i);
	endtask
	task automatic read(input logic [7:0] o, input logic [15:0] m, input logic [15:0] exp);
		int n;
		off = o;
		rd = 1;
		@(negedge clock_i);
		rd = 0;
		for (n = 0; n < 4 && rv !== 1'b1; n++) @(negedge clock_i);
		if (n == 4) begin
			mismatches++;
			end_of_test();
		end
		cmp(rdata & m, exp);
		@(negedge clock_i);
	endtask
	// expected requests: flag and enable, then the gates
	function automatic logic exp_irq(logic [2:0] c, logic [2:0] f, logic h, logic m);
		return |(c & f) && h && m;
	endfunction
	function automatic logic exp_pme(logic [2:0] c, logic [2:0] f, logic p, logic s);
		return |(c & f) && (!s || p);
	endfunction
	// flags first, enables later, then partial clear
	task automatic trial(input logic [2:0] c, input logic [2:0] f, input logic [3:0] g, input logic [2:0] w);
		write(sees_pkg::STATUS_OFFSET, 16'h011F);
		write(sees_pkg::CONTROL_OFFSET, 16'h0000);
		{pe, msi, hpi} = g[2:0];
		ps = g[3] ? 2'(32'h1 + {$random(seed)} % 32'h3) : 2'h0;
		fset = f;
		@(negedge clock_i);
		fset = 0;
		write(sees_pkg::CONTROL_OFFSET, {13'h0000, c});
		@(negedge clock_i);
		cmp_bit(irq, exp_irq(c, f, g[0], g[1]));
		cmp_bit(pme, exp_pme(c, f, g[2], g[3]));
		write(sees_pkg::STATUS_OFFSET, {8'hFE, 3'h7, 2'h0, w});
		repeat (20) @(negedge clock_i);
		read(sees_pkg::STATUS_OFFSET, 16'hFFFF, {8'h00, lvl, 1'b1, 1'b0, f & ~w});
		read(sees_pkg::CONTROL_OFFSET, 16'h0007, {13'h0000, c});
	endtask
	// main sequence
	initial begin
		repeat (12) @(negedge clock_i);
		reset_i = 0;
		@(negedge clock_i);
		read(sees_pkg::STATUS_OFFSET, 16'hFFFF, 16'h0010);
		read(8'h00, 16'hFFFF, 16'h0000);
		trial(3'h4, 3'h4, 4'h3, 3'h4);
		trial(3'h2, 3'h7, 4'h1, 3'h2);
		trial(3'h1, 3'h1, 4'hC, 3'h0);
		trial(3'h5, 3'h3, 4'h8, 3'h7);
		repeat (40) begin
			lvl = 3'($random(seed));
			trial(3'($random(seed)), 3'($random(seed)), 4'($random(seed)), 3'($random(seed)));
		end
		// frozen clock enable drops a control write
		write(sees_pkg::CONTROL_OFFSET, 16'h0002);
		en = 0;
		write(sees_pkg::CONTROL_OFFSET, 16'h0005);
		en = 1;
		read(sees_pkg::CONTROL_OFFSET, 16'hFFFF, 16'h0002);
		// second reset in mid-run restores the reset values
		reset_i = 1;
		repeat (2) @(negedge clock_i);
		reset_i = 0;
		@(negedge clock_i);
		cmp_bit(irq, 1'b0);
		read(sees_pkg::STATUS_OFFSET, 16'hFFFF, 16'h0010);
		read(sees_pkg::CONTROL_OFFSET, 16'hFFFF, 16'h0000);
		end_of_test();
	end
endmodule // testbench
